/* hw/asp_pkg.sv */
// constants shared by both ends of the converter serial port
// Overview of operation
// RL1 - strap high: device drives shift clock
// RL2 - self clock toggles only after strobe low
// RL3 - release clock at strobe high or word end
// RL4 - strap low: host supplies shift clock
// RL5 - device accepts continuous or gapped external clock
// RL6 - select low control, high data or calibration
// RL7 - filter sync resets digital filter state
// RL8 - master clock runs outside standby
// RL9 - control bit switches burnout current source
// RL10 - master clock nominally 10 MHz; the core clock standing in for it runs at 100 MHz (CLK_NS 10)
// RL11 - external mode: ready high after read falling edge
// RL12 - shift only while one strobe low
package asp_pkg;
    localparam int WORD_BITS        = 24;
    localparam int FIFO_DEPTH       = 4;
    localparam int CLK_NS           = 10;
    localparam int LINK_HALF_NS     = 80;
    localparam int SELF_HIGH_NS     = 40;
    localparam int SELF_LOW_NS      = 120;
    localparam int LEAD_NS          = 80;
    localparam int GAP_NS           = 400;
    localparam int SYNC_PULSE_NS    = 1000;
    localparam int CTRL_BURNOUT_POS = 5;

    localparam logic [7:0] LINK_HALF_CYC = 8'((LINK_HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SELF_HIGH_CYC = 8'((SELF_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SELF_LOW_CYC  = 8'((SELF_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] LEAD_CYC      = 8'((LEAD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] GAP_CYC       = 8'((GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SYNC_CYC      = 8'((SYNC_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0] LAST_BIT      = 5'(WORD_BITS - 1);
    localparam logic [2:0] BURST_LAST    = 3'h7;

    localparam logic [WORD_BITS-1:0] CTRL_RESET = 24'h000000;
    localparam logic [WORD_BITS-1:0] CAL_RESET  = 24'h000000;

    typedef logic [WORD_BITS-1:0] asp_word_t;
endpackage : asp_pkg

/* hw/asp_link_if.sv */
// pin bundle between converter port and host, with wire resolution
`timescale 1ns/1ps
interface asp_link_if;
    logic self_clock_mode;
    logic register_select;
    logic filter_sync;
    logic receive_frame_strobe_n;
    logic transmit_frame_strobe_n;
    logic result_ready_n;
    logic sclk_dev_o;
    logic sclk_dev_oe;
    logic sclk_host_o;
    logic sclk_host_oe;
    logic sdata_dev_o;
    logic sdata_dev_oe;
    logic sdata_host_o;
    logic sdata_host_oe;
    logic sclk;
    logic sdata;

    // undriven wires rest high as if pulled up
    assign sclk  = sclk_dev_oe ? sclk_dev_o : (sclk_host_oe ? sclk_host_o : 1'h1);
    assign sdata = sdata_dev_oe ? sdata_dev_o : (sdata_host_oe ? sdata_host_o : 1'h1);

    modport device_end (
        input  self_clock_mode, register_select, filter_sync,
        input  receive_frame_strobe_n, transmit_frame_strobe_n, sclk, sdata,
        output sclk_dev_o, sclk_dev_oe, sdata_dev_o, sdata_dev_oe, result_ready_n
    );
    modport host_end (
        input  result_ready_n, sclk, sdata,
        output self_clock_mode, register_select, filter_sync,
        output receive_frame_strobe_n, transmit_frame_strobe_n,
        output sclk_host_o, sclk_host_oe, sdata_host_o, sdata_host_oe
    );
endinterface : asp_link_if

/* hw/asp_device.sv */
// converter end of the serial port, with its result fifo
`timescale 1ns/1ps
module asp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } asp_fifo_s;
    asp_fifo_s r;
    asp_fifo_s n;
    logic      push;
    logic      pop;

    // full and empty come from the count so both sides see honest state
    assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data  = r.mem[r.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr] = in_data;
            n.wr        = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + AW'(1);
        end
        if (pop) begin
            n.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + AW'(1);
        end
        n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule : asp_fifo

module asp_device (
    input  wire logic           core_clk,
    input  wire logic           rst,
    asp_link_if.device_end      link,
    input  wire asp_pkg::asp_word_t conv_data,
    input  wire logic           conv_valid,
    output logic                conv_ready,
    output asp_pkg::asp_word_t  ctrl_word,
    output asp_pkg::asp_word_t  cal_word,
    output logic                burnout_enable,
    output logic                filter_reset
);
    import asp_pkg::*;

    typedef struct packed {
        logic [1:0] sclk_s;
        logic [1:0] rfs_s;
        logic [1:0] tfs_s;
        logic [1:0] sdata_s;
        logic [1:0] sel_s;
        logic [1:0] sync_s;
        logic [1:0] mode_s;
        logic       sclk_d;
        logic       active;
        logic       rd;
        logic       sel;
        logic       done;
        logic       popped;
        logic       rdy_hold;
        logic       pop;
        logic [4:0] nbits;
        logic [7:0] pcnt;
        asp_word_t  sh;
        asp_word_t  ctrl;
        asp_word_t  cal;
        logic       sclk_o;
        logic       sclk_oe;
        logic       sdata_o;
        logic       sdata_oe;
        logic       rdy_n;
        logic       freset;
    } asp_dev_s;

    asp_dev_s  r;
    asp_dev_s  n;
    logic      fifo_valid;
    asp_word_t fifo_data;
    logic      frame;
    logic      self_mode;
    logic      fall_ev;
    logic      rise_ev;

    // results wait here until the host reads them; full stalls the converter
    asp_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (conv_valid),
        .in_ready  (conv_ready),
        .in_data   (conv_data),
        .out_valid (fifo_valid),
        .out_ready (r.pop),
        .out_data  (fifo_data)
    );

    // pins seen only after the second sampling flop
    assign frame     = !r.rfs_s[1] || !r.tfs_s[1];                      // [RL12]
    assign self_mode = r.mode_s[1];                                      // [RL1] [RL4]

    // shift edges: own generator in self mode, sampled pin otherwise
    always_comb begin
        if (self_mode) begin
            fall_ev = r.sclk_oe && r.sclk_o && (r.pcnt == 8'h01);
            rise_ev = r.sclk_oe && !r.sclk_o && (r.pcnt == 8'h01);
        end else begin
            fall_ev = r.sclk_d && !r.sclk_s[1];                           // [RL5]
            rise_ev = !r.sclk_d && r.sclk_s[1];                           // [RL5]
        end
    end

    // frame sequencing, shifting and register updates
    always_comb begin
        n         = r;
        n.sclk_s  = {r.sclk_s[0], link.sclk};
        n.rfs_s   = {r.rfs_s[0], link.receive_frame_strobe_n};
        n.tfs_s   = {r.tfs_s[0], link.transmit_frame_strobe_n};
        n.sdata_s = {r.sdata_s[0], link.sdata};
        n.sel_s   = {r.sel_s[0], link.register_select};
        n.sync_s  = {r.sync_s[0], link.filter_sync};
        n.mode_s  = {r.mode_s[0], link.self_clock_mode};
        n.sclk_d  = r.sclk_s[1];
        n.pop     = 1'h0;
        n.freset  = r.sync_s[1];                                          // [RL7]
        if (!r.active) begin
            // edges with both strobes high are never acted on
            if (frame) begin                                              // [RL12] [RL2]
                n.active   = 1'h1;
                n.rd       = !r.rfs_s[1];
                n.sel      = r.sel_s[1];
                n.done     = 1'h0;
                n.nbits    = '0;
                n.rdy_hold = 1'h0;
                n.popped   = !(r.sel_s[1] && fifo_valid);
                n.sclk_oe  = self_mode;                                   // [RL1]
                n.sclk_o   = 1'h1;
                n.pcnt     = SELF_HIGH_CYC;
                n.sdata_oe = !r.rfs_s[1];
                // select low reaches control, high the data or calibration word
                if (!r.sel_s[1]) begin                                    // [RL6]
                    n.sh = r.ctrl;
                end else if (fifo_valid) begin
                    n.sh = fifo_data;
                end else begin
                    n.sh = r.cal;
                end
            end
        end else if (!frame) begin
            // strobe back high ends the frame and frees both pins
            n.active   = 1'h0;
            n.sclk_oe  = 1'h0;                                            // [RL3]
            n.sdata_oe = 1'h0;
            n.rdy_hold = 1'h0;
        end else if (!r.done) begin
            if (self_mode) begin
                n.pcnt = r.pcnt - 8'h01;
                if (fall_ev) begin                                        // [RL2]
                    n.sclk_o = 1'h0;
                    n.pcnt   = SELF_LOW_CYC;
                end else if (rise_ev) begin
                    n.sclk_o = 1'h1;
                    n.pcnt   = SELF_HIGH_CYC;
                end
            end
            if (fall_ev && r.rd) begin
                n.sdata_o  = r.sh[WORD_BITS-1];
                n.sh       = {r.sh[WORD_BITS-2:0], 1'h0};
                n.rdy_hold = r.sel;                                       // [RL11]
                if (!r.popped) begin
                    n.pop    = 1'h1;
                    n.popped = 1'h1;
                end
            end
            if (rise_ev) begin
                n.nbits = r.nbits + 5'h01;
                if (!r.rd) begin
                    n.sh = {r.sh[WORD_BITS-2:0], r.sdata_s[1]};
                end
                if (r.nbits == LAST_BIT) begin
                    // word complete: give the clock pin back
                    n.done    = 1'h1;
                    n.sclk_oe = 1'h0;                                     // [RL3]
                    if (!r.rd && !r.sel) begin
                        n.ctrl = n.sh;                                    // [RL6]
                    end else if (!r.rd) begin
                        n.cal = n.sh;                                     // [RL6]
                    end
                end
            end
        end
        // ready shows a waiting result unless a data read has begun shifting
        n.rdy_n = n.rdy_hold || !fifo_valid;                              // [RL11]
    end

    // strobes and clock sample as idle-high so reset starts no frame
    always_ff @(posedge core_clk) begin
        if (rst) begin
            r        <= '0;
            r.sclk_s <= 2'h3;
            r.rfs_s  <= 2'h3;
            r.tfs_s  <= 2'h3;
            r.sclk_d <= 1'h1;
            r.rdy_n  <= 1'h1;
            r.ctrl   <= CTRL_RESET;
            r.cal    <= CAL_RESET;
        end else begin
            r <= n;
        end
    end

    // pin and user outputs straight from state
    assign link.sclk_dev_o     = r.sclk_o;
    assign link.sclk_dev_oe    = r.sclk_oe;                               // [RL1] [RL4]
    assign link.sdata_dev_o    = r.sdata_o;
    assign link.sdata_dev_oe   = r.sdata_oe;
    assign link.result_ready_n = r.rdy_n;
    assign ctrl_word           = r.ctrl;
    assign cal_word            = r.cal;
    assign burnout_enable      = r.ctrl[CTRL_BURNOUT_POS];                // [RL9]
    assign filter_reset        = r.freset;                                // [RL7]
endmodule : asp_device

/* hw/asp_host.sv */
// host end: runs one word transfer per command over the port
`timescale 1ns/1ps
module asp_host (
    input  wire logic               core_clk,
    input  wire logic               rst,
    asp_link_if.host_end            link,
    input  wire logic               mode_self,
    input  wire logic               gapped,
    input  wire logic               sync_req,
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire logic               cmd_write,
    input  wire logic               cmd_select,
    input  wire asp_pkg::asp_word_t cmd_data,
    output logic                    rsp_valid,
    output asp_pkg::asp_word_t      rsp_data,
    output logic                    data_ready
);
    import asp_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_LEAD = 3'h1,
        H_XFER = 3'h2,
        H_GAP  = 3'h3,
        H_TAIL = 3'h4
    } asp_hst_e;

    typedef struct packed {
        asp_hst_e   st;
        logic [1:0] sclk_s;
        logic [1:0] sdata_s;
        logic [1:0] rdy_s;
        logic       sclk_d;
        logic       wr;
        logic       self;
        logic       gap;
        logic [4:0] nbits;
        logic [7:0] pcnt;
        logic [7:0] scnt;
        asp_word_t  sh;
        logic       sclk_o;
        logic       sclk_oe;
        logic       sdata_o;
        logic       sdata_oe;
        logic       rfs_n;
        logic       tfs_n;
        logic       sel;
        logic       fsync;
        logic       cready;
        logic       rvalid;
        asp_word_t  rdata;
        logic       dready;
    } asp_hst_s;

    asp_hst_s r;
    asp_hst_s n;
    logic     fall_ev;
    logic     rise_ev;

    // own divider in external mode, sampled device clock in self mode
    always_comb begin
        if (r.self) begin
            fall_ev = r.sclk_d && !r.sclk_s[1];
            rise_ev = !r.sclk_d && r.sclk_s[1];
        end else begin
            fall_ev = r.sclk_o && (r.pcnt == 8'h01);
            rise_ev = !r.sclk_o && (r.pcnt == 8'h01);
        end
    end

    // transfer sequencing
    always_comb begin
        n         = r;
        n.sclk_s  = {r.sclk_s[0], link.sclk};
        n.sdata_s = {r.sdata_s[0], link.sdata};
        n.rdy_s   = {r.rdy_s[0], link.result_ready_n};
        n.sclk_d  = r.sclk_s[1];
        n.rvalid  = 1'h0;
        n.dready  = !r.rdy_s[1];                                          // [RL11]
        // filter sync stretched to its least width
        if (sync_req) begin
            n.scnt = SYNC_CYC;
        end else if (r.scnt != 8'h00) begin
            n.scnt = r.scnt - 8'h01;
        end
        n.fsync = sync_req || (r.scnt > 8'h01);                           // [RL7]
        case (r.st)
            H_IDLE: begin
                n.self = mode_self;
                n.gap  = gapped;
                if (cmd_valid && r.cready) begin
                    n.cready = 1'h0;
                    n.wr     = cmd_write;
                    n.sel    = cmd_select;                                // [RL6]
                    n.sh     = cmd_data;
                    n.nbits  = '0;
                    n.pcnt   = LEAD_CYC;
                    n.st     = H_LEAD;
                end
            end
            H_LEAD: begin
                // select settles before the strobe falls
                n.pcnt = r.pcnt - 8'h01;
                if (r.pcnt == 8'h01) begin
                    n.rfs_n    = r.wr;
                    n.tfs_n    = !r.wr;
                    n.sdata_oe = r.wr;
                    n.sclk_oe  = !r.self;                                 // [RL4]
                    n.sclk_o   = 1'h1;
                    n.pcnt     = LINK_HALF_CYC;
                    n.st       = H_XFER;
                end
            end
            H_XFER: begin
                if (!r.self) begin
                    n.pcnt = (r.pcnt == 8'h01) ? LINK_HALF_CYC : r.pcnt - 8'h01;
                    if (r.pcnt == 8'h01) begin
                        n.sclk_o = !r.sclk_o;                             // [RL4]
                    end
                end
                if (fall_ev && r.wr) begin
                    n.sdata_o = r.sh[WORD_BITS-1];
                    n.sh      = {r.sh[WORD_BITS-2:0], 1'h0};
                end
                if (rise_ev) begin
                    n.nbits = r.nbits + 5'h01;
                    if (!r.wr) begin
                        n.sh = {r.sh[WORD_BITS-2:0], r.sdata_s[1]};
                    end
                    if (r.nbits == LAST_BIT) begin
                        n.pcnt = LINK_HALF_CYC;
                        n.st   = H_TAIL;
                    end else if (r.gap && !r.self && (r.nbits[2:0] == BURST_LAST)) begin
                        // burst boundary: clock parks high for a while
                        n.pcnt = GAP_CYC;                                 // [RL5]
                        n.st   = H_GAP;
                    end
                end
            end
            H_GAP: begin
                n.pcnt = r.pcnt - 8'h01;
                if (r.pcnt == 8'h01) begin
                    n.pcnt = LINK_HALF_CYC;
                    n.st   = H_XFER;
                end
            end
            H_TAIL: begin
                // strobe rises only after the last high phase
                n.pcnt = r.pcnt - 8'h01;
                if (r.pcnt == 8'h01) begin
                    n.rfs_n    = 1'h1;                                    // [RL12]
                    n.tfs_n    = 1'h1;
                    n.sclk_oe  = 1'h0;
                    n.sdata_oe = 1'h0;
                    n.rvalid   = !r.wr;
                    n.rdata    = r.sh;
                    n.cready   = 1'h1;
                    n.st       = H_IDLE;
                end
            end
            default: begin
                n.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r        <= '0;
            r.st     <= H_IDLE;
            r.sclk_s <= 2'h3;
            r.rdy_s  <= 2'h3;
            r.sclk_d <= 1'h1;
            r.sclk_o <= 1'h1;
            r.rfs_n  <= 1'h1;
            r.tfs_n  <= 1'h1;
            r.cready <= 1'h1;
        end else begin
            r <= n;
        end
    end

    // strap follows the latched mode, changing only between transfers
    assign link.self_clock_mode         = r.self;                         // [RL1] [RL4]
    assign link.register_select         = r.sel;
    assign link.filter_sync             = r.fsync;
    assign link.receive_frame_strobe_n  = r.rfs_n;
    assign link.transmit_frame_strobe_n = r.tfs_n;
    assign link.sclk_host_o             = r.sclk_o;
    assign link.sclk_host_oe            = r.sclk_oe;
    assign link.sdata_host_o            = r.sdata_o;
    assign link.sdata_host_oe           = r.sdata_oe;
    assign cmd_ready                    = r.cready;
    assign rsp_valid                    = r.rvalid;
    assign rsp_data                     = r.rdata;
    assign data_ready                   = r.dready;
endmodule : asp_host

/* verification/asp_link_props.sv */
// concurrent checks on the converter port wires
`timescale 1ns/1ps
module asp_link_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic self_clock_mode,
    input wire logic register_select,
    input wire logic receive_frame_strobe_n,
    input wire logic transmit_frame_strobe_n,
    input wire logic result_ready_n,
    input wire logic sclk_dev_o,
    input wire logic sclk_dev_oe,
    input wire logic sclk_host_oe,
    input wire logic sdata_dev_oe,
    input wire logic sdata_host_oe,
    input wire logic sclk
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // any strobe low means a frame is open
    logic frame_open;
    assign frame_open = !receive_frame_strobe_n || !transmit_frame_strobe_n;

    // self clock holds high before its first bit
    sequence s_self_lead;
        sclk_dev_o[*4];
    endsequence
    // host lowers the clock inside a data read
    sequence s_ext_read_fall;
        !self_clock_mode && register_select && !receive_frame_strobe_n && $fell(sclk);
    endsequence

    a_ext_dev_quiet: assert property (
        !self_clock_mode && !$past(self_clock_mode, 4) |-> !sclk_dev_oe)
        else $error("device drove clock in external mode");
    a_self_host_quiet: assert property (
        self_clock_mode |-> !sclk_host_oe)
        else $error("host drove clock in self mode");
    a_self_start_frame: assert property (
        $rose(sclk_dev_oe) |-> frame_open && self_clock_mode)
        else $error("self clock started outside a frame");
    a_self_lead_high: assert property (
        $rose(sclk_dev_oe) |-> s_self_lead)
        else $error("self clock lead too short");
    a_self_low_width: assert property (
        $fell(sclk_dev_o) && sclk_dev_oe |-> (!sclk_dev_o && sclk_dev_oe)[*8])
        else $error("self clock low phase too short");
    a_idle_release: assert property (
        (!frame_open)[*5] |-> !sclk_dev_oe)
        else $error("clock still driven after frame end");
    a_ready_after_fall: assert property (
        s_ext_read_fall |-> ##[1:6] result_ready_n)
        else $error("result ready not cleared by read");
    a_data_one_driver: assert property (
        !(sdata_dev_oe && sdata_host_oe))
        else $error("data line driven by both ends");
    a_data_read_frame: assert property (
        $rose(sdata_dev_oe) |-> !receive_frame_strobe_n)
        else $error("data driven outside a read frame");
    a_ext_edge_frame: assert property (
        !self_clock_mode && $fell(sclk) |-> sclk_host_oe && frame_open)
        else $error("external clock edge outside a frame");
endmodule : asp_link_props

/* verification/asp_bench.sv */
// self-checking bench: host end and converter end joined over the port
`timescale 1ns/1ps
module asp_bench;
    import asp_pkg::*;
    logic      core_clk, rst, conv_valid, conv_ready, burnout_enable, filter_reset;
    logic      mode_self, gapped, sync_req, cmd_valid, cmd_ready, cmd_write, cmd_select;
    logic      rsp_valid, data_ready;
    asp_word_t conv_data, ctrl_word, cal_word, cmd_data, rsp_data, q;
    asp_word_t conv_words [4];
    int        fail_count = 0;
    int        n_compared = 0;

    asp_link_if asp_link_if_i ();
    asp_device asp_device_i (.core_clk, .rst, .link(asp_link_if_i.device_end), .conv_data, .conv_valid,
        .conv_ready, .ctrl_word, .cal_word, .burnout_enable, .filter_reset);
    asp_host asp_host_i (.core_clk, .rst, .link(asp_link_if_i.host_end), .mode_self, .gapped, .sync_req,
        .cmd_valid, .cmd_ready, .cmd_write, .cmd_select, .cmd_data, .rsp_valid, .rsp_data, .data_ready);
    asp_link_props asp_link_props_i (.core_clk, .rst, .self_clock_mode(asp_link_if_i.self_clock_mode),
        .register_select(asp_link_if_i.register_select),
        .receive_frame_strobe_n(asp_link_if_i.receive_frame_strobe_n),
        .transmit_frame_strobe_n(asp_link_if_i.transmit_frame_strobe_n),
        .result_ready_n(asp_link_if_i.result_ready_n), .sclk_dev_o(asp_link_if_i.sclk_dev_o),
        .sclk_dev_oe(asp_link_if_i.sclk_dev_oe), .sclk_host_oe(asp_link_if_i.sclk_host_oe),
        .sdata_dev_oe(asp_link_if_i.sdata_dev_oe), .sdata_host_oe(asp_link_if_i.sdata_host_oe),
        .sclk(asp_link_if_i.sclk));

    // free-running core clock, never stopped, stands in for the master clock
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic stop_test;
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // compare one word, one flag
    task automatic chk_word(input string what, input asp_word_t exp, input asp_word_t got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    // one command; writes end at cmd_ready, reads at the response pulse
    task automatic xfer(input logic wr, input logic sel, input asp_word_t d);
        int n;
        n = 0;
        cmd_write = wr;
        cmd_select = sel;
        cmd_data = d;
        cmd_valid = 1'h1;
        @(posedge core_clk);
        #1 cmd_valid = 1'h0;
        while (n < 2000 && (wr ? cmd_ready !== 1'h1 : rsp_valid !== 1'h1)) begin
            @(posedge core_clk);
            #1 n++;
        end
        q = rsp_data;
        chk_bit("transfer done", 1'h1, n < 2000);
        // let the device's synchronised write land
        repeat (4) @(posedge core_clk);
        #1;
    endtask : xfer
    task automatic rd(input logic sel, input asp_word_t exp);
        xfer(1'h0, sel, 24'h000000);
        chk_word("read data", exp, q);
    endtask : rd

    // hang guard, far beyond the expected few thousand cycles
    initial begin
        #400000;
        fail_count++;
        stop_test();
    end

    // main sequence
    initial begin
        int n;
        rst = 1'h1;
        conv_valid = 1'h0;
        conv_data = 24'h000000;
        mode_self = 1'h0;
        gapped = 1'h0;
        sync_req = 1'h0;
        cmd_valid = 1'h0;
        cmd_write = 1'h0;
        cmd_select = 1'h0;
        cmd_data = 24'h000000;
        conv_words = '{24'h800001, 24'h7FFFFE, 24'hFFFFFF, 24'h000000};
        repeat (4) @(posedge core_clk);
        #1 rst = 1'h0;
        chk_word("control word", CTRL_RESET, ctrl_word);
        chk_word("calibration word", CAL_RESET, cal_word);
        chk_bit("burnout", 1'h0, burnout_enable);
        chk_bit("result ready", 1'h0, data_ready);
        // external clock: control and calibration through the select line
        xfer(1'h1, 1'h0, 24'h5A5A20);
        chk_bit("burnout", 1'h1, burnout_enable);
        xfer(1'h1, 1'h1, 24'h123456);
        chk_word("calibration word", 24'h123456, cal_word);
        rd(1'h0, 24'h5A5A20);
        rd(1'h1, 24'h123456);
        // fill the fifo until it refuses a fifth word
        for (int i = 0; i < 4; i++) begin
            chk_bit("conv ready", 1'h1, conv_ready);
            conv_data = conv_words[i];
            conv_valid = 1'h1;
            @(posedge core_clk);
            #1;
        end
        conv_data = 24'hC0FFEE;
        repeat (3) @(posedge core_clk);
        #1 conv_valid = 1'h0;
        chk_bit("conv ready", 1'h0, conv_ready);
        chk_bit("result ready", 1'h1, data_ready);
        // drain in order, gapped clock on every other word
        for (int i = 0; i < 4; i++) begin
            gapped = i[0];
            rd(1'h1, conv_words[i]);
        end
        gapped = 1'h0;
        chk_bit("result ready", 1'h0, data_ready);
        chk_bit("conv ready", 1'h1, conv_ready);
        rd(1'h1, 24'h123456);
        // self clocking: device makes the shift clock
        mode_self = 1'h1;
        repeat (4) @(posedge core_clk);
        #1 xfer(1'h1, 1'h0, 24'hA5A5DF);
        chk_bit("burnout", 1'h0, burnout_enable);
        rd(1'h0, 24'hA5A5DF);
        conv_data = 24'h0F0F0F;
        conv_valid = 1'h1;
        @(posedge core_clk);
        #1 conv_valid = 1'h0;
        rd(1'h1, 24'h0F0F0F);
        // filter restart from the host's sync request
        sync_req = 1'h1;
        @(posedge core_clk);
        #1 sync_req = 1'h0;
        n = 0;
        while (n < 300 && filter_reset !== 1'h1) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk_bit("filter reset", 1'h1, filter_reset);
        n = 0;
        while (n < 300 && filter_reset !== 1'h0) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk_bit("filter reset", 1'h0, filter_reset);
        stop_test();
    end
endmodule : asp_bench
